// ### hdl/mapc_top.v
// motor algorithm and pin configuration registers with their users
`timescale 1ns/1ps
`default_nettype none
// Function
// - probe timeout fault after selected number of 16-bit timer overflows
// - probe limit codes 0..3 give 5, 10, 20, 40 overflows
// - four-bit code picks unaligned closed-loop acceleration, F equals B (2000)
// - motor declared stopped after stop condition lasts selected time
// - motor declared running after run condition lasts selected time
// - brake low current accepted after persisting 50 to 500 ms
// - filter bit set passes bus voltage unfiltered, clear keeps filter
// - style bit 0 brakes on low side, 1 brakes by aligning
// - override code 0 or 3 takes brake request from pin
// - override code 1 ignores pin and brakes per style bit
// - override code 2 ignores pin, no brake, no align
// - tuning word at 5c, all zero after reset
// - pin word at 60, all zero after reset
`include "mapc_regs.vh"
module mapc_top #(
  parameter integer CLK_HZ = 50000000,
  parameter integer TMR_W  = 16,
  parameter integer VBUS_W = 12
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              ce,
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              probe_active,
  output wire              probe_timeout_fault,
  output wire [13:0]       unaligned_loop_accel,
  input  wire              stop_cond,
  output wire              motor_stopped,
  input  wire              run_cond,
  output wire              motor_running,
  input  wire              hold_current_low,
  output wire              hold_current_ok,
  input  wire [VBUS_W-1:0] vbus_in,
  input  wire              vbus_valid,
  output wire [VBUS_W-1:0] vbus_out,
  input  wire              brake_pin,
  output wire              brake_lowside,
  output wire              brake_align
);

  localparam [31:0] CYC_PER_MS = CLK_HZ / 1000;
  localparam integer SH = `MAPC_VFILT_SHIFT;
  localparam [1:0] RESP_OK  = 2'h0;
  localparam [1:0] RESP_ERR = 2'h2;
  localparam [7:0] ALGO_ADR = `MAPC_ALGO_OFS;
  localparam [7:0] PIN_ADR  = `MAPC_PIN_OFS;
  localparam [5:0] ALGO_IDX = ALGO_ADR[7:2];
  localparam [5:0] PIN_IDX  = PIN_ADR[7:2];

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  reg  [31:0] algo_q;
  reg  [31:0] pin_q;
  reg         aw_held_q;
  reg  [7:0]  aw_addr_q;
  reg         w_held_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;
  reg  [31:0] bmask;
  reg  [31:0] rd_val;
  reg         rd_hit;
  wire        wr_go;
  wire        aw_take;
  wire        w_take;
  wire        ar_take;

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign aw_take = ce & s_axi_awvalid & s_axi_awready;
  assign w_take  = ce & s_axi_wvalid & s_axi_wready;
  assign ar_take = ce & s_axi_arvalid & s_axi_arready;
  assign wr_go   = ce & aw_held_q & w_held_q & ~bvalid_q;

  // byte-enable mask from the held strobes
  always @* begin
    bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
             {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  end

  // read decode; unmapped word reads zero with an error answer
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr[7:2])
      ALGO_IDX: rd_val = algo_q & `MAPC_ALGO_WMASK;
      PIN_IDX:  rd_val = pin_q;
      default:             rd_hit = 1'b0;
    endcase
  end

  // address and data are caught in either order, then written together
  always @(posedge clk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OK;
      algo_q    <= `MAPC_ALGO_RST;
      pin_q     <= `MAPC_PIN_RST;
    end else if (ce) begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= RESP_OK;
        case (aw_addr_q[7:2])
          ALGO_IDX: algo_q <= (algo_q & ~(bmask &
            `MAPC_ALGO_WMASK)) | (w_data_q & bmask &
            `MAPC_ALGO_WMASK);
          PIN_IDX: pin_q <= (pin_q & ~bmask) |
            (w_data_q & bmask);
          default: bresp_q <= RESP_ERR;
        endcase
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OK;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val;
        rresp_q  <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // field extraction
  // ****************************************************************
  wire [1:0] pto_code  = algo_q[`MAPC_PTO_LSB+1 -: 2];
  wire [3:0] acc_code  = algo_q[`MAPC_ACC_LSB+3 -: 4];
  wire [1:0] stop_code = algo_q[`MAPC_STOP_LSB+1 -: 2];
  wire [1:0] run_code  = algo_q[`MAPC_RUN_LSB+1 -: 2];
  wire [1:0] hold_code = algo_q[`MAPC_HOLD_LSB+1 -: 2];
  wire       filt_off  = pin_q[`MAPC_FILT_BIT];
  wire       style     = pin_q[`MAPC_STYLE_BIT];
  wire [1:0] brk_code  = pin_q[`MAPC_BRK_LSB+1 -: 2];

  // ****************************************************************
  // rotor angle probe timeout
  // ****************************************************************
  reg [TMR_W-1:0] ptmr_q;
  reg [7:0]       povf_q;
  reg             pfault_q;
  reg [7:0]       pto_lim;

  // overflow limit per code
  always @* begin
    case (pto_code)
      2'h0:    pto_lim = `MAPC_PTO_OVF0;
      2'h1:    pto_lim = `MAPC_PTO_OVF1;
      2'h2:    pto_lim = `MAPC_PTO_OVF2;
      default: pto_lim = `MAPC_PTO_OVF3;
    endcase
  end

  // timer runs while probing; fault holds until probing ends
  always @(posedge clk) begin
    if (rst) begin
      ptmr_q   <= {TMR_W{1'b0}};
      povf_q   <= 8'h00;
      pfault_q <= 1'b0;
    end else if (ce) begin
      if (!probe_active) begin
        ptmr_q   <= {TMR_W{1'b0}};
        povf_q   <= 8'h00;
        pfault_q <= 1'b0;
      end else begin
        ptmr_q <= ptmr_q + 1'b1;
        if (&ptmr_q && !pfault_q) begin
          povf_q <= povf_q + 8'h01;
          if (povf_q + 8'h01 >= pto_lim)
            pfault_q <= 1'b1;
        end
      end
    end
  end
  assign probe_timeout_fault = pfault_q;

  // ****************************************************************
  // unaligned closed-loop acceleration, in 0.1 Hz/s units
  // ****************************************************************
  reg [13:0] acc_q;
  reg [13:0] acc_d;

  // code to rate table
  always @* begin
    case (acc_code)
      4'h0:    acc_d = 14'h0001;
      4'h1:    acc_d = 14'h000a;
      4'h2:    acc_d = 14'h0014;
      4'h3:    acc_d = 14'h001e;
      4'h4:    acc_d = 14'h0032;
      4'h5:    acc_d = 14'h0064;
      4'h6:    acc_d = 14'h00c8;
      4'h7:    acc_d = 14'h012c;
      4'h8:    acc_d = 14'h0190;
      4'h9:    acc_d = 14'h01f4;
      4'ha:    acc_d = 14'h03e8;
      4'hb:    acc_d = 14'h07d0;
      4'hc:    acc_d = 14'h1388;
      4'hd:    acc_d = 14'h1d4c;
      4'he:    acc_d = 14'h2710;
      default: acc_d = 14'h07d0;
    endcase
  end

  // registered rate output
  always @(posedge clk) begin
    if (rst)
      acc_q <= 14'h0001;
    else if (ce)
      acc_q <= acc_d;
  end
  assign unaligned_loop_accel = acc_q;

  // ****************************************************************
  // persistence detectors: stopped, running, brake low current
  // ****************************************************************
  function [31:0] ms_to_cyc;
    input [15:0] ms;
    reg   [47:0] p;
    begin
      p = ms * CYC_PER_MS;
      ms_to_cyc = p[31:0];
    end
  endfunction

  function [15:0] spin_ms;
    input [1:0] code;
    begin
      case (code)
        2'h0:    spin_ms = `MAPC_SPIN_MS0;
        2'h1:    spin_ms = `MAPC_SPIN_MS1;
        2'h2:    spin_ms = `MAPC_SPIN_MS2;
        default: spin_ms = `MAPC_SPIN_MS3;
      endcase
    end
  endfunction

  function [15:0] hold_ms;
    input [1:0] code;
    begin
      case (code)
        2'h0:    hold_ms = `MAPC_HOLD_MS0;
        2'h1:    hold_ms = `MAPC_HOLD_MS1;
        2'h2:    hold_ms = `MAPC_HOLD_MS2;
        default: hold_ms = `MAPC_HOLD_MS3;
      endcase
    end
  endfunction

  wire [2:0]  pers_cond = {hold_current_low, run_cond, stop_cond};
  wire [31:0] pers_tgt [0:2];
  wire [2:0]  pers_out;

  assign pers_tgt[0] = ms_to_cyc(spin_ms(stop_code));
  assign pers_tgt[1] = ms_to_cyc(spin_ms(run_code));
  assign pers_tgt[2] = ms_to_cyc(hold_ms(hold_code));

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pers
      reg [31:0] cnt_q;
      reg        out_q;
      // count consecutive cycles of the condition, saturating at target
      always @(posedge clk) begin
        if (rst) begin
          cnt_q <= 32'h00000000;
          out_q <= 1'b0;
        end else if (ce) begin
          if (!pers_cond[gi]) begin
            cnt_q <= 32'h00000000;
            out_q <= 1'b0;
          end else begin
            if (cnt_q < pers_tgt[gi])
              cnt_q <= cnt_q + 32'h00000001;
            out_q <= (cnt_q + 32'h00000001 >= pers_tgt[gi]);
          end
        end
      end
      assign pers_out[gi] = out_q;
    end
  endgenerate

  assign motor_stopped   = pers_out[0];
  assign motor_running   = pers_out[1];
  assign hold_current_ok = pers_out[2];

  // ****************************************************************
  // bus voltage filter
  // ****************************************************************
  reg [VBUS_W+SH-1:0] vacc_q;
  reg [VBUS_W-1:0]    vout_q;
  wire [VBUS_W+SH-1:0] vacc_d = vacc_q + {{SH{1'b0}}, vbus_in} -
                                {{SH{1'b0}}, vacc_q[VBUS_W+SH-1:SH]};

  // first-order low pass, or straight through when switched off
  always @(posedge clk) begin
    if (rst) begin
      vacc_q <= {(VBUS_W+SH){1'b0}};
      vout_q <= {VBUS_W{1'b0}};
    end else if (ce && vbus_valid) begin
      if (filt_off) begin
        vacc_q <= {vbus_in, {SH{1'b0}}};
        vout_q <= vbus_in;
      end else begin
        vacc_q <= vacc_d;
        vout_q <= vacc_d[VBUS_W+SH-1:SH];
      end
    end
  end
  assign vbus_out = vout_q;

  // ****************************************************************
  // brake pin and override
  // ****************************************************************
  reg brk_s1_q;
  reg brk_s2_q;
  reg brk_s3_q;
  reg brk_lvl_q;
  reg lowside_q;
  reg align_q;
  reg brk_req;

  // three-stage pin synchroniser; level moves when stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      brk_s1_q  <= 1'b0;
      brk_s2_q  <= 1'b0;
      brk_s3_q  <= 1'b0;
      brk_lvl_q <= 1'b0;
    end else if (ce) begin
      brk_s1_q <= brake_pin;
      brk_s2_q <= brk_s1_q;
      brk_s3_q <= brk_s2_q;
      if (brk_s2_q == brk_s3_q)
        brk_lvl_q <= brk_s3_q;
    end
  end

  // request source selected by the override code
  always @* begin
    case (brk_code)
      `MAPC_BRK_FORCE: brk_req = 1'b1;
      `MAPC_BRK_OFF:   brk_req = 1'b0;
      default:         brk_req = brk_lvl_q;
    endcase
  end

  // style bit steers the request to low-side or align braking
  always @(posedge clk) begin
    if (rst) begin
      lowside_q <= 1'b0;
      align_q   <= 1'b0;
    end else if (ce) begin
      lowside_q <= brk_req & ~style;
      align_q   <= brk_req & style;
    end
  end
  assign brake_lowside = lowside_q;
  assign brake_align   = align_q;

endmodule
`default_nettype wire

// ### include/mapc_regs.vh
// register offsets, field positions, reset values and timing tables
`ifndef MAPC_REGS_VH
`define MAPC_REGS_VH
// ****************************************************************
// register offsets and reset values
// ****************************************************************
`define MAPC_ALGO_OFS    8'h5c
`define MAPC_PIN_OFS     8'h60
`define MAPC_ALGO_RST    32'h00000000
`define MAPC_PIN_RST     32'h00000000
`define MAPC_ALGO_WMASK  32'hffff3c18
`define MAPC_PIN_WMASK   32'hffffffff
// ****************************************************************
// field positions
// ****************************************************************
`define MAPC_PTO_LSB     5'd20
`define MAPC_ACC_LSB     5'd16
`define MAPC_STOP_LSB    5'd12
`define MAPC_RUN_LSB     5'd10
`define MAPC_HOLD_LSB    5'd3
`define MAPC_FILT_BIT    5'd19
`define MAPC_STYLE_BIT   5'd2
`define MAPC_BRK_LSB     5'd0
// ****************************************************************
// brake override codes
// ****************************************************************
`define MAPC_BRK_PIN0    2'h0
`define MAPC_BRK_FORCE   2'h1
`define MAPC_BRK_OFF     2'h2
`define MAPC_BRK_PIN3    2'h3
// ****************************************************************
// timer overflow limits for the probe timeout
// ****************************************************************
`define MAPC_PTO_OVF0    8'h05
`define MAPC_PTO_OVF1    8'h0a
`define MAPC_PTO_OVF2    8'h14
`define MAPC_PTO_OVF3    8'h28
// ****************************************************************
// persistence times in ms
// ****************************************************************
`define MAPC_SPIN_MS0    16'h0001
`define MAPC_SPIN_MS1    16'h0005
`define MAPC_SPIN_MS2    16'h0032
`define MAPC_SPIN_MS3    16'h0064
`define MAPC_HOLD_MS0    16'h0032
`define MAPC_HOLD_MS1    16'h0064
`define MAPC_HOLD_MS2    16'h00fa
`define MAPC_HOLD_MS3    16'h01f4
// ****************************************************************
// bus voltage filter strength (right shift)
// ****************************************************************
`define MAPC_VFILT_SHIFT 3
`endif

// ### verification/mapc_top_props.sv
// assertion checker for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module mapc_top_props #(
  parameter integer TMR_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic probe_active,
  input wire logic probe_timeout_fault,
  input wire logic stop_cond,
  input wire logic motor_stopped,
  input wire logic run_cond,
  input wire logic motor_running,
  input wire logic hold_current_low,
  input wire logic hold_current_ok,
  input wire logic brake_lowside,
  input wire logic brake_align,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int MIN_ACT = 5 * (1 << TMR_W) - 2;
  logic [31:0] act_q;
  // cycles of a running probe
  always_ff @(posedge clk) begin
    act_q <= (rst || !probe_active) ? 32'h0 : act_q + 32'h1;
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_probe_drop;
    ce && !probe_active;
  endsequence
  sequence s_stop_rise;
    !motor_stopped ##1 motor_stopped;
  endsequence
  a_fault_clear: assert property (s_probe_drop |=> !probe_timeout_fault)
    else $error("probe fault held after probe ended");
  a_fault_late: assert property ($rose(probe_timeout_fault) |-> act_q >= MIN_ACT)
    else $error("probe fault came too early");
  a_stop_cause: assert property (s_stop_rise |-> $past(stop_cond, 5))
    else $error("stopped without lasting cause");
  a_stop_drop: assert property (ce && !stop_cond |=> !motor_stopped)
    else $error("stopped held without cause");
  a_run_cause: assert property ($rose(motor_running) |-> $past(run_cond))
    else $error("running without cause");
  a_run_drop: assert property (ce && !run_cond |=> !motor_running)
    else $error("running held without cause");
  a_hold_drop: assert property (ce && !hold_current_low |=> !hold_current_ok)
    else $error("low current held without cause");
  a_brake_excl: assert property (!(brake_lowside && brake_align))
    else $error("both brake styles active");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_once: assert property (ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TW = 4;
  logic        clk, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, b;
  logic        probe_active, probe_timeout_fault, vbus_valid, brake_pin;
  logic        brake_lowside, brake_align;
  logic [13:0] unaligned_loop_accel;
  logic [2:0]  cond;
  wire  [2:0]  held;
  logic [11:0] vbus_in, vbus_out;
  logic [33:0] exp_q[$];
  int          errors, check_count, cyc, n;
  int          ovf[4] = '{5, 10, 20, 40};
  int          rate[16] = '{1, 10, 20, 30, 50, 100, 200, 300, 400, 500,
                            1000, 2000, 5000, 7500, 10000, 2000};
  mapc_top #(.CLK_HZ(10000), .TMR_W(TW), .VBUS_W(12)) DUT (
    .clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .probe_active(probe_active), .probe_timeout_fault(probe_timeout_fault),
    .unaligned_loop_accel(unaligned_loop_accel), .stop_cond(cond[0]),
    .motor_stopped(held[0]), .run_cond(cond[1]), .motor_running(held[1]),
    .hold_current_low(cond[2]), .hold_current_ok(held[2]),
    .vbus_in(vbus_in), .vbus_valid(vbus_valid), .vbus_out(vbus_out),
    .brake_pin(brake_pin), .brake_lowside(brake_lowside),
    .brake_align(brake_align));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // each channel is released at the edge that takes it
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // response taken at the edge where bvalid meets bready
    do @(posedge clk); while (!s_axi_bvalid);
    check(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] want);
    exp_q.push_back(want);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
  endtask
  // counts cycles until a raised condition is declared
  task automatic persist(input int s, input int want);
    n = 0;
    cond[s] <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (!held[s] && n < 2000);
    check(n >= want - 1 && n <= want + 1, 1'b1);
    @(posedge clk);
    cond[s] <= 1'b0;
    tick(2);
    check(held[s], 1'b0);
  endtask
  // read answers compared against the oldest note
  always @(negedge clk) begin
    if (s_axi_rvalid && exp_q.size() > 0)
      check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(77673));
    {rst, ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = 8'hff;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, probe_active} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {cond, vbus_in, vbus_valid, brake_pin} = 17'h0;
    tick(4);
    rst <= 1'b0;
    rd(8'h5c, 34'h0);
    rd(8'h60, 34'h0);
    wr(8'h5c, 32'hffffffff, 2'h0);
    rd(8'h5c, 34'hffff3c18);
    d = $urandom;
    wr(8'h60, d & 32'hfff7fff8, 2'h0);
    rd(8'h60, {2'h0, d & 32'hfff7fff8});
    // only the low byte lane is written
    s_axi_wstrb <= 4'h1;
    wr(8'h60, 32'h00000000, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(8'h60, {2'h0, d & 32'hfff7ff00});
    wr(8'h40, d, 2'h2);
    rd(8'h40, {2'h2, 32'h0});
    vbus_in <= 12'h800;
    vbus_valid <= 1'b1;
    tick(1);
    vbus_valid <= 1'b0;
    tick(2);
    check(vbus_out, 12'h100);
    wr(8'h60, 32'h00080000, 2'h0);
    vbus_in <= 12'($urandom);
    vbus_valid <= 1'b1;
    tick(1);
    vbus_valid <= 1'b0;
    tick(2);
    check(vbus_out, vbus_in);
    for (int c = 0; c < 16; c++) begin
      wr(8'h5c, c << 16, 2'h0);
      tick(2);
      check(unaligned_loop_accel, rate[c]);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h5c, c << 20, 2'h0);
      probe_active <= 1'b1;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!probe_timeout_fault && n < 2000);
      check(n >= ovf[c] * 16 - 2 && n <= ovf[c] * 16 + 2, 1'b1);
      @(posedge clk);
      probe_active <= 1'b0;
      tick(2);
      check(probe_timeout_fault, 1'b0);
    end
    wr(8'h5c, 32'h00001800, 2'h0);
    persist(0, 50);
    persist(1, 500);
    persist(2, 500);
    // clock enable low freezes the stop persistence count
    ce <= 1'b0;
    cond[0] <= 1'b1;
    tick(80);
    check(held[0], 1'b0);
    ce <= 1'b1;
    cond[0] <= 1'b0;
    tick(2);
    for (int k = 0; k < 16; k++) begin
      brake_pin <= 1'($urandom);
      wr(8'h60, k % 8, 2'h0);
      tick(8);
      b = (k % 4 == 1) || ((k % 4 == 0 || k % 4 == 3) && brake_pin);
      check({brake_align, brake_lowside}, {b && k[2], b && !k[2]});
    end
    results();
  end
endmodule
bind mapc_top mapc_top_props #(.TMR_W(TMR_W)) u_props (
  .clk(clk), .rst(rst), .ce(ce), .probe_active(probe_active),
  .probe_timeout_fault(probe_timeout_fault), .stop_cond(stop_cond),
  .motor_stopped(motor_stopped), .run_cond(run_cond),
  .motor_running(motor_running), .hold_current_low(hold_current_low),
  .hold_current_ok(hold_current_ok), .brake_lowside(brake_lowside),
  .brake_align(brake_align), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
